/* verilog/cfb_streamer.sv */
// burst ordering and fill streaming for a secondary cache line
// assumes system beats are acknowledged by s_ack with data in s_rdata
// Notes on behaviour
// - processor burst starts at requested double word, runs on, wraps in four double words.
// - array addresses are generated here; processor address stepping is ignored.
// - system burst order picked at reset: critical first or zero first.
// - critical first: system burst starts at processor's double word, wraps.
// - zero first: governed system bursts always start at double word zero.
// - chosen order applies to line fills and snoop copybacks.
// - replacement copybacks always start at double word zero.
// - one address per system beat: four for short lines, eight long.
// - fill data goes to processor bus while written into array.
// - streamed data valid on processor bus one clock after array access.
// - short line critical first: all four beats streamed, done at last.
// - zero first: forwarding starts only at the critical double word.
// - zero first: after fill, wrap and supply leading double words.
// - system bus error during streamed fill goes to processor bus.
// - long line: last processor beat waits for the fill to finish.
// - long critical first: stream first half, wait states for second half.
// - long critical first, critical word not first of its half: resume streaming after the wrap until fill ends.
// - long zero first: wait states during the other half's four beats.
// - after good zero first fill, drive leading double word to processor.
// - secondary hit returns four 64-bit beats in critical first order.
`timescale 1ns/1ns

module cfb_streamer
  import cfb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_zero_first,
  input wire logic cfg_long_line,
  input wire logic req_valid,
  input wire cfb_req_e req_kind,
  input wire logic [DW_IDX_W-1:0] req_dw,
  output logic req_ready_q,
  output logic done_q,
  output logic s_addr_valid_q,
  output logic s_write_q,
  output logic [DW_IDX_W-1:0] s_addr_q,
  output logic [DATA_W-1:0] s_wdata_q,
  input wire logic s_ack,
  input wire logic s_err,
  input wire logic [DATA_W-1:0] s_rdata,
  output logic p_ta_q,
  output logic p_tea_q,
  output logic p_wait_q,
  output logic [DW_IDX_W-1:0] p_dw_q,
  output logic [DATA_W-1:0] p_data_q
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cfb_state_e state_q, state_d;
  cfb_req_e kind_q;
  logic strap_done_q, zero_q, long_q;
  logic [2:0] crit_q, sbase_q, rd_dw_q;
  logic [3:0] scnt_q;
  logic [2:0] pcnt_q;
  logic rd_pend_q;

  logic [2:0] mask, pexp, cur_s, nxt_s, sbase_d;
  logic start, fill_beat, last_s, proc_last, stream;

  cfb_ram_if #(.DW(DATA_W), .AW(DW_IDX_W)) ram_if ();

  cfb_line_ram #(.DEPTH(LINE_DWS)) u_ram
  (
    .clk(clk),
    .port(ram_if.ram)
  );

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strap_done_q <= 1'b0;
      zero_q <= 1'b0;
      long_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      zero_q <= cfg_zero_first;
      long_q <= cfg_long_line;
    end
  end

  // ------------------------------------------------------------
  // beat decisions
  // ------------------------------------------------------------
  always_comb
  begin
    mask = long_q ? LONG_MASK : SHORT_MASK;
    // processor order from the captured critical word only
    pexp = {crit_q[2] & long_q, crit_q[1:0] + pcnt_q[1:0]};
    cur_s = (sbase_q + scnt_q[2:0]) & mask;
    nxt_s = (sbase_q + scnt_q[2:0] + 3'h1) & mask;
    last_s = scnt_q == (long_q ? LONG_BEATS - 4'h1 : SHORT_BEATS - 4'h1);
    start = state_q == ST_IDLE && req_ready_q && req_valid;
    // replacement copyback ignores the strap
    sbase_d = (req_kind == REQ_REPL_CB || zero_q) ? DW_ZERO : (req_dw & mask);
    fill_beat = state_q == ST_FILL && s_ack;
    proc_last = pcnt_q == PROC_BEATS - 3'h1;
    // forward only the beat the processor expects; hold its last beat until fill ends
    stream = fill_beat && !s_err && s_addr_q == pexp && pcnt_q < PROC_BEATS
             && (!proc_last || last_s);
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          unique case (req_kind)
            REQ_FILL: state_d = ST_FILL;
            REQ_HIT: state_d = ST_REPLAY;
            REQ_SNOOP_CB, REQ_REPL_CB: state_d = ST_CB_RD;
          endcase
        end
      end
      ST_FILL:
      begin
        if (fill_beat && s_err)
        begin
          state_d = ST_IDLE;
        end
        else if (fill_beat && last_s)
        begin
          // wrap to the leading double words still owed
          state_d = (pcnt_q + {2'h0, stream} < PROC_BEATS) ? ST_REPLAY : ST_IDLE;
        end
      end
      ST_REPLAY: state_d = proc_last ? ST_IDLE : ST_REPLAY;
      ST_CB_RD: state_d = ST_CB_LD;
      ST_CB_LD: state_d = ST_CB_WR;
      ST_CB_WR: state_d = !s_ack ? ST_CB_WR : (s_err || last_s) ? ST_IDLE : ST_CB_RD;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      req_ready_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_ready_q <= strap_done_q && state_d == ST_IDLE;
      done_q <= state_q != ST_IDLE && state_d == ST_IDLE;
    end
  end

  // ------------------------------------------------------------
  // counters and captured request
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      kind_q <= REQ_FILL;
      crit_q <= DW_ZERO;
      sbase_q <= DW_ZERO;
      scnt_q <= SCNT_ZERO;
      pcnt_q <= PCNT_ZERO;
    end
    else if (start)
    begin
      kind_q <= req_kind;
      crit_q <= req_dw & mask;
      sbase_q <= sbase_d;
      scnt_q <= SCNT_ZERO;
      pcnt_q <= PCNT_ZERO;
    end
    else
    begin
      scnt_q <= scnt_q + {3'h0, fill_beat || (state_q == ST_CB_WR && s_ack)};
      pcnt_q <= pcnt_q + {2'h0, stream || state_q == ST_REPLAY};
    end
  end

  // ------------------------------------------------------------
  // data array port
  // ------------------------------------------------------------
  assign ram_if.we = fill_beat && !s_err;
  assign ram_if.waddr = s_addr_q;
  assign ram_if.wdata = s_rdata;
  assign ram_if.re = state_q == ST_REPLAY || state_q == ST_CB_RD;
  assign ram_if.raddr = state_q == ST_REPLAY ? pexp : cur_s;

  // ------------------------------------------------------------
  // system side
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_addr_valid_q <= 1'b0;
      s_write_q <= 1'b0;
      s_addr_q <= DW_ZERO;
      s_wdata_q <= '0;
    end
    else if (start && req_kind == REQ_FILL)
    begin
      s_addr_valid_q <= 1'b1;
      s_write_q <= 1'b0;
      s_addr_q <= sbase_d;
    end
    else if (fill_beat)
    begin
      s_addr_valid_q <= !(s_err || last_s);
      s_addr_q <= nxt_s;
    end
    else if (state_q == ST_CB_LD)
    begin
      s_addr_valid_q <= 1'b1;
      s_write_q <= 1'b1;
      s_addr_q <= cur_s;
      s_wdata_q <= ram_if.rdata;
    end
    else if (state_q == ST_CB_WR && s_ack)
    begin
      s_addr_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // processor side
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_pend_q <= 1'b0;
      rd_dw_q <= DW_ZERO;
      p_ta_q <= 1'b0;
      p_tea_q <= 1'b0;
      p_wait_q <= 1'b0;
      p_dw_q <= DW_ZERO;
      p_data_q <= '0;
    end
    else
    begin
      rd_pend_q <= state_q == ST_REPLAY;
      rd_dw_q <= pexp;
      p_ta_q <= stream || rd_pend_q;
      p_tea_q <= fill_beat && s_err;
      p_wait_q <= ((state_q == ST_FILL && !(fill_beat && s_err)) || state_q == ST_REPLAY)
                  && !stream && !rd_pend_q;
      if (stream)
      begin
        p_dw_q <= s_addr_q;
        p_data_q <= s_rdata;
      end
      else if (rd_pend_q)
      begin
        p_dw_q <= rd_dw_q;
        p_data_q <= ram_if.rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [3:0] ack_cnt_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_cnt_q <= SCNT_ZERO;
    end
    else if ($rose(s_addr_valid_q) && !s_write_q)
    begin
      ack_cnt_q <= {3'h0, s_ack};
    end
    else if (state_q == ST_IDLE && !s_addr_valid_q)
    begin
      ack_cnt_q <= SCNT_ZERO;
    end
    else if ((fill_beat || (state_q == ST_CB_WR && s_ack)))
    begin
      ack_cnt_q <= ack_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  stream_lag_a: assert property (
    stream |=> p_ta_q && p_data_q == $past(s_rdata))
    else $error("streamed beat not on processor bus one clock later");
  crit_start_a: assert property (
    start && req_kind == REQ_FILL && !zero_q |=> s_addr_q == crit_q && s_addr_valid_q)
    else $error("critical first fill did not start at critical word");
  zero_start_a: assert property (
    start && req_kind != REQ_HIT && zero_q |=> sbase_q == DW_ZERO)
    else $error("zero first burst did not start at word zero");
  repl_zero_a: assert property (
    start && req_kind == REQ_REPL_CB |=> ##2 s_addr_valid_q && s_addr_q == DW_ZERO)
    else $error("replacement copyback did not start at word zero");
  err_prop_a: assert property (
    fill_beat && s_err |=> p_tea_q && !s_addr_valid_q && state_q == ST_IDLE)
    else $error("system error not passed to processor");
  hold_last_a: assert property (
    fill_beat && !last_s && proc_last |-> !stream)
    else $error("last processor beat sent before fill completed");
  wait_ins_a: assert property (
    fill_beat && !s_err && !last_s && !stream |=> p_wait_q && !p_ta_q)
    else $error("no wait state while fill beat not forwarded");
  beat_count_a: assert property (
    $fell(s_addr_valid_q) && !s_write_q && !$past(s_err)
    |-> ack_cnt_q == (long_q ? LONG_BEATS : SHORT_BEATS))
    else $error("wrong number of system burst beats");
  strap_hold_a: assert property (
    strap_done_q |=> $stable(zero_q) && $stable(long_q))
    else $error("ordering strap changed after capture");
  proc_order_a: assert property (
    stream && pcnt_q == PCNT_ZERO |=> p_ta_q && p_dw_q == crit_q)
    else $error("processor burst did not open with critical word");
  zero_long_c: cover property (zero_q && long_q && fill_beat && last_s ##1 state_q == ST_REPLAY);
  crit_long_c: cover property (!zero_q && long_q && fill_beat && last_s && stream);
  err_c: cover property (fill_beat && s_err && pcnt_q != PCNT_ZERO);
  hit_c: cover property (state_q == ST_REPLAY && proc_last);
  snoop_cb_c: cover property (kind_q == REQ_SNOOP_CB && state_q == ST_CB_WR && s_ack && last_s);

endmodule : cfb_streamer

/* verilog/cfb_pkg.sv */
// shared constants and types of the cache fill burst streamer
// assumes a single 100 MHz clock and 64-bit double words
package cfb_pkg;

  // ------------------------------------------------------------
  // widths and line geometry
  // ------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int DW_IDX_W = 3;
  localparam int LINE_DWS = 8;
  localparam logic [3:0] SHORT_BEATS = 4'h4;
  localparam logic [3:0] LONG_BEATS = 4'h8;
  localparam logic [2:0] SHORT_MASK = 3'h3;
  localparam logic [2:0] LONG_MASK = 3'h7;
  localparam logic [2:0] DW_ZERO = 3'h0;
  localparam logic [2:0] PROC_BEATS = 3'h4;
  localparam logic [2:0] PCNT_ZERO = 3'h0;
  localparam logic [3:0] SCNT_ZERO = 4'h0;

  // ------------------------------------------------------------
  // request kinds and controller states
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    REQ_FILL = 2'h0,
    REQ_HIT = 2'h1,
    REQ_SNOOP_CB = 2'h2,
    REQ_REPL_CB = 2'h3
  } cfb_req_e;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_FILL = 3'h1,
    ST_REPLAY = 3'h3,
    ST_CB_RD = 3'h2,
    ST_CB_LD = 3'h6,
    ST_CB_WR = 3'h7
  } cfb_state_e;

endpackage : cfb_pkg

/* verilog/cfb_ram_if.sv */
// port bundle between the streamer and its line data array
// assumes one write port and one registered read port, same clock
`timescale 1ns/1ns

interface cfb_ram_if #(
  parameter int DW = 64,
  parameter int AW = 3
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output re, output raddr,
                input rdata);
  modport ram (input we, input waddr, input wdata, input re, input raddr,
               output rdata);
endinterface : cfb_ram_if

/* verilog/cfb_line_ram.sv */
// one cache line of data array, read data from a register
// assumes the controller never reads and writes the same word at once
`timescale 1ns/1ns

module cfb_line_ram
  import cfb_pkg::*;
#(
  parameter int DEPTH = LINE_DWS
)
(
  input wire logic clk,
  cfb_ram_if.ram port
);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      mem[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (port.re)
    begin
      rdata_q <= mem[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule : cfb_line_ram

/* test/cfb_mem_model.sv */
// system memory model answering the streamer's burst beats
// assumes the bench pulses clr with every request
`timescale 1ns/1ns

module cfb_mem_model
  import cfb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic s_addr_valid_q,
  input wire logic [DW_IDX_W-1:0] s_addr_q,
  input wire logic slow,
  input wire logic clr,
  input wire logic [3:0] err_beat,
  input wire logic [31:0] salt,
  output logic s_ack,
  output logic s_err,
  output logic [DATA_W-1:0] s_rdata
);
  logic [1:0] wait_q;
  logic [3:0] beat_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_ack <= 1'b0;
      s_err <= 1'b0;
      s_rdata <= 64'h0;
      wait_q <= 2'h0;
      beat_q <= 4'h0;
    end
    else
    begin
      s_ack <= 1'b0;
      s_err <= 1'b0;
      // released data lines toggle so no stale value looks valid
      s_rdata <= ~s_rdata;
      if (clr)
        beat_q <= 4'h0;
      if (s_addr_valid_q && !s_ack && wait_q == 2'h0)
      begin
        s_ack <= 1'b1;
        s_err <= (beat_q == err_beat);
        s_rdata <= {salt, 29'h0, s_addr_q};
        beat_q <= beat_q + 4'h1;
        wait_q <= slow ? 2'($urandom_range(3)) : 2'h0;
      end
      else if (s_addr_valid_q && wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule : cfb_mem_model

/* test/cfb_streamer_test.sv */
// self-checking bench of the burst streamer against a memory model
// assumes one request at a time and straps taken after reset
`timescale 1ns/1ns

module cfb_streamer_test import cfb_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfg_zero_first = 1'b0;
  logic cfg_long_line = 1'b0;
  logic req_valid = 1'b0;
  cfb_req_e req_kind = REQ_FILL;
  logic [2:0] req_dw = 3'h0;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic [3:0] err_beat = 4'hf;
  logic [31:0] salt = 32'h0;
  logic req_ready_q, done_q, s_addr_valid_q, s_write_q, s_ack, s_err;
  logic p_ta_q, p_tea_q, p_wait_q;
  logic [2:0] s_addr_q, p_dw_q, c;
  logic [63:0] s_wdata_q, s_rdata, p_data_q;
  logic [3:0] sq[$];
  logic [63:0] wq[$];
  logic [63:0] dq[$];
  logic [2:0] pq[$];
  int tq[$];
  int ack_cyc[8];
  int cyc, last_ack, last_ta, tea_n, wait_n, err_count, n_checks;
  logic cz, cl, hcr = 1'b0, wpend = 1'b0;
  logic [31:0] lsalt;

  cfb_streamer dut_u (.clk(clk), .reset(reset), .cfg_zero_first(cfg_zero_first),
    .cfg_long_line(cfg_long_line), .req_valid(req_valid), .req_kind(req_kind),
    .req_dw(req_dw), .req_ready_q(req_ready_q), .done_q(done_q),
    .s_addr_valid_q(s_addr_valid_q), .s_write_q(s_write_q), .s_addr_q(s_addr_q),
    .s_wdata_q(s_wdata_q), .s_ack(s_ack), .s_err(s_err), .s_rdata(s_rdata),
    .p_ta_q(p_ta_q), .p_tea_q(p_tea_q), .p_wait_q(p_wait_q), .p_dw_q(p_dw_q),
    .p_data_q(p_data_q));

  cfb_mem_model mem_u (.clk(clk), .reset(reset), .s_addr_valid_q(s_addr_valid_q),
    .s_addr_q(s_addr_q), .slow(slow), .clr(clr), .err_beat(err_beat), .salt(salt),
    .s_ack(s_ack), .s_err(s_err), .s_rdata(s_rdata));

  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // bus monitor and hang guard
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (s_addr_valid_q && s_ack)
    begin
      sq.push_back({s_write_q, s_addr_q});
      wq.push_back(s_wdata_q);
      ack_cyc[s_addr_q] = cyc;
      last_ack = cyc;
    end
    if (p_ta_q)
    begin
      pq.push_back(p_dw_q);
      dq.push_back(p_data_q);
      tq.push_back(cyc);
      last_ta = cyc;
    end
    if (p_tea_q)
      tea_n++;
    if (p_wait_q)
      wait_n++;
    // a fill beat of the other line half must leave the processor waiting
    if (wpend)
      check("wait", 64'(p_wait_q && !p_ta_q), 64'h1);
    wpend = s_addr_valid_q && s_ack && !s_err && !s_write_q && cl && s_addr_q[2] != hcr;
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input string w, input logic [63:0] s, input logic [63:0] x);
    n_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", w, x, s);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic do_op(input cfb_req_e k, input logic [2:0] cr, input logic [3:0] eb);
    int i, n, ns;
    logic [2:0] m, b, e, st;
    sq.delete();
    wq.delete();
    pq.delete();
    dq.delete();
    tq.delete();
    tea_n = 0;
    wait_n = 0;
    hcr = cr[2];
    if (k == REQ_FILL)
    begin
      lsalt = $urandom;
      salt <= lsalt;
    end
    err_beat <= eb;
    slow <= 1'($urandom_range(1));
    i = 0;
    @(posedge clk);
    while (req_ready_q !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      i++;
    end
    req_valid <= 1'b1;
    req_kind <= k;
    req_dw <= cr;
    clr <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    clr <= 1'b0;
    i = 0;
    while (done_q !== 1'b1 && i < 300)
    begin
      @(posedge clk);
      i++;
    end
    check("done", 64'(done_q), 64'h1);
    check("ready", 64'(req_ready_q), 64'h1);
    repeat (4) @(posedge clk);
    m = cl ? 3'h7 : 3'h3;
    n = (k == REQ_HIT) ? 0 : (cl ? 8 : 4);
    ns = (eb < n) ? eb + 1 : n;
    st = (k == REQ_REPL_CB || (cz && k != REQ_HIT)) ? 3'h0 : cr & m;
    check("beats", 64'(sq.size()), 64'(ns));
    for (i = 0; i < sq.size() && i < ns; i++)
    begin
      e = 3'(st + i) & m;
      check("saddr", 64'(sq[i]), 64'({k[1], e}));
      if (k[1])
        check("wdata", wq[i], {lsalt, 29'h0, e});
    end
    if (k[1])
      return;
    check("error", 64'(tea_n), 64'(eb < n));
    if (eb < n)
    begin
      check("cut", 64'(pq.size() < 4), 64'h1);
      return;
    end
    b = cl ? cr & 3'h4 : 3'h0;
    check("pbeats", 64'(pq.size()), 64'h4);
    for (i = 0; i < pq.size() && i < 4; i++)
    begin
      e = b | (3'(cr + i) & 3'h3);
      check("pdw", 64'(pq[i]), 64'(e));
      check("pdata", dq[i], {lsalt, 29'h0, e});
      if (k == REQ_FILL && !cz && !cl)
        check("stream", 64'(tq[i]), 64'(ack_cyc[e] + 1));
    end
    if (k != REQ_FILL)
      return;
    check("crit", 64'(tq[0]), 64'(ack_cyc[cr & m] + 1));
    check("hold", 64'(last_ta > last_ack), 64'h1);
    if (cl)
      check("wait", 64'(wait_n > 0), 64'h1);
    if (cl && !cz && cr[1:0] != 2'h0)
      check("resume", 64'(tq[3]), 64'(ack_cyc[pq[3]] + 1));
  endtask : do_op

  initial
  begin
    void'($urandom(92));
    for (int g = 0; g < 4; g++)
    begin
      reset <= 1'b1;
      cz = g[0];
      cl = g[1];
      cfg_zero_first <= cz;
      cfg_long_line <= cl;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      // straps flipped once captured
      cfg_zero_first <= ~cz;
      cfg_long_line <= ~cl;
      for (int j = 0; j < 6; j++)
      begin
        c = (j == 0) ? 3'h0 : (j == 1) ? 3'h7 : 3'($urandom_range(7));
        do_op(REQ_FILL, c, 4'hf);
        do_op(REQ_HIT, 3'($urandom_range(7)), 4'hf);
        do_op(REQ_SNOOP_CB, c, 4'hf);
        do_op(REQ_REPL_CB, 3'($urandom_range(7)), 4'hf);
      end
      do_op(REQ_FILL, 3'h1, 4'($urandom_range(cl ? 7 : 3)));
    end
    complete_run();
  end
endmodule : cfb_streamer_test
